// [include/interval_clock_pkg.sv]
// How it works
// - a trigger-two event sets the trigger-two flag, bit 15.
// - start leading edge clears trigger-two flag unless external start was already enabled.
// - bit 14 enables an interrupt request on trigger-two events.
// - start leading edge clears the external start enable, bit 13.
// - start assertion clears the flag-overrun bit 12.
// - counter overflow sets bit 7; start leading edge always clears it.
// - bit 6 enables an interrupt request on counter overflow.
// - in repeated-interval mode overflow leaves the start bit at one.
// - start stays set until software clears it; single-interval overflow clears it.
package interval_clock_pkg;

    // register byte addresses
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_COUNT  = 4'h4;
    localparam logic [3:0] ADR_PRESET = 4'h8;

    // control word bit positions
    localparam int B_T2_FLAG  = 15;
    localparam int B_T2_IEN   = 14;
    localparam int B_EXT_EN   = 13;
    localparam int B_OVERRUN  = 12;
    localparam int B_MAINT_HI = 11;
    localparam int B_MAINT_LO = 8;
    localparam int B_OV_FLAG  = 7;
    localparam int B_OV_IEN   = 6;
    localparam int B_RATE_HI  = 5;
    localparam int B_RATE_LO  = 3;
    localparam int B_MODE_HI  = 2;
    localparam int B_MODE_LO  = 1;
    localparam int B_GO       = 0;

    localparam int CTRL_W  = 16;
    localparam int RATE_W  = 3;
    localparam int MODE_W  = 2;
    localparam int MAINT_W = 4;
    localparam int PRESC_W = 7;

    typedef enum logic [1:0]
    {
        MODE_SINGLE   = 2'h0,
        MODE_REPEAT   = 2'h1,
        MODE_EXT_TIME = 2'h2,
        MODE_EXT_ZERO = 2'h3
    } mode_e;

    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] PRESET_RESET = 16'h0000;

endpackage

// [rtl/interval_clock_control_status.sv]
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none

module interval_clock_control_status
#(
    parameter int CNT_W = 16
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // classic wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // external trigger pin, asynchronous
    input  wire logic        external_trigger_two,
    // interrupt request level
    output logic             irq_request
);

    if (CNT_W < 2 || CNT_W > 16)
    begin
        $error("CNT_W must lie between 2 and 16");
    end

    // the prescaler must reach the slowest rate, 2**RATE_W - 1 bits of it
    if (interval_clock_pkg::PRESC_W < (1 << interval_clock_pkg::RATE_W) - 1)
    begin
        $error("prescaler too narrow for the rate field");
    end

    typedef struct packed
    {
        logic                                    ack;
        logic [31:0]                             rdata;
        logic                                    sync1;
        logic                                    sync2;
        logic                                    trig_prev;
        logic                                    go_prev;
        logic                                    t2_flag;
        logic                                    t2_ien;
        logic                                    ext_en;
        logic                                    ext_en_prev;
        logic                                    overrun;
        logic [interval_clock_pkg::MAINT_W-1:0]  maint;
        logic                                    ov_flag;
        logic                                    ov_ien;
        logic [interval_clock_pkg::RATE_W-1:0]   rate;
        interval_clock_pkg::mode_e               mode;
        logic                                    go;
        logic [interval_clock_pkg::PRESC_W-1:0]  presc;
        logic [CNT_W-1:0]                        count;
        logic [CNT_W-1:0]                        preset;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    // the prescaler divides by two to the power of the rate field
    // rate 0 ticks every clock, the top rate every 128 clocks
    function automatic logic rate_tick(input logic [interval_clock_pkg::RATE_W-1:0] r,
                                       input logic [interval_clock_pkg::PRESC_W-1:0] p);
        logic [interval_clock_pkg::PRESC_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < interval_clock_pkg::PRESC_W; i++)
        begin
            mask[i] = (i < int'(r));
        end
        return (p & mask) == mask;
    endfunction

    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0])
        begin
            res[7:0] = wd[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // unmapped addresses read as zero so probing software sees no stale data
    function automatic logic [31:0] read_mux(input logic [3:0]  a,
                                             input logic [15:0] ctrl,
                                             input logic [15:0] cnt,
                                             input logic [15:0] pre);
        logic [31:0] res;
        res = 32'h0000_0000;
        unique case (a)
            interval_clock_pkg::ADR_CTRL:
            begin
                res = {16'h0000, ctrl};
            end
            interval_clock_pkg::ADR_COUNT:
            begin
                res = {16'h0000, cnt};
            end
            interval_clock_pkg::ADR_PRESET:
            begin
                res = {16'h0000, pre};
            end
            default:
            begin
                res = 32'h0000_0000;
            end
        endcase
        return res;
    endfunction

    logic [15:0] ctrl_word;
    logic        presc_done;
    logic        t2_req;
    logic        ov_req;
    logic        bus_req;
    logic        wr_now;
    logic        trig_event;
    logic        tick;
    logic        overflow;
    logic        go_edge;
    logic [15:0] wval;
    logic [15:0] preset16;
    logic [15:0] count16;

    assign preset16 = 16'(state_ff.preset);
    assign count16  = 16'(state_ff.count);

    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[interval_clock_pkg::B_T2_FLAG] = state_ff.t2_flag;
        ctrl_word[interval_clock_pkg::B_T2_IEN]  = state_ff.t2_ien;
        ctrl_word[interval_clock_pkg::B_EXT_EN]  = state_ff.ext_en;
        ctrl_word[interval_clock_pkg::B_OVERRUN] = state_ff.overrun;
        ctrl_word[interval_clock_pkg::B_MAINT_HI:interval_clock_pkg::B_MAINT_LO] = state_ff.maint;
        ctrl_word[interval_clock_pkg::B_OV_FLAG] = state_ff.ov_flag;
        ctrl_word[interval_clock_pkg::B_OV_IEN]  = state_ff.ov_ien;
        ctrl_word[interval_clock_pkg::B_RATE_HI:interval_clock_pkg::B_RATE_LO] = state_ff.rate;
        ctrl_word[interval_clock_pkg::B_MODE_HI:interval_clock_pkg::B_MODE_LO] = state_ff.mode;
        ctrl_word[interval_clock_pkg::B_GO]      = state_ff.go;
    end

    assign bus_req    = cyc_i && stb_i;
    // a write lands at the edge where the master sees ack
    assign wr_now     = bus_req && we_i && state_ff.ack;
    assign trig_event = state_ff.sync2 && !state_ff.trig_prev;
    assign presc_done = rate_tick(state_ff.rate, state_ff.presc);
    assign tick       = state_ff.go && presc_done;
    // the count is stale while the preset loads, so no overflow at the start edge
    assign overflow   = tick && !go_edge && (state_ff.count == {CNT_W{1'b1}});
    // leading edge of start seen one cycle after it rose; side effects follow then
    assign go_edge    = state_ff.go && !state_ff.go_prev;

    always_comb
    begin
        nxt_state = state_ff;
        wval      = 16'h0000;

        // two flops guard the logic against metastability on the asynchronous pin
        nxt_state.sync1     = external_trigger_two;
        nxt_state.sync2     = state_ff.sync1;
        nxt_state.trig_prev = state_ff.sync2;
        nxt_state.go_prev   = state_ff.go;
        nxt_state.ext_en_prev = state_ff.ext_en;

        // wishbone: one wait state, ack for one cycle, then dropped
        nxt_state.ack = bus_req && !state_ff.ack;
        // data is latched when the request is taken, so it stands through the ack cycle
        if (bus_req && !state_ff.ack && !we_i)
        begin
            nxt_state.rdata = read_mux(adr_i, ctrl_word, count16, preset16);
        end


        if (wr_now && adr_i == interval_clock_pkg::ADR_CTRL)
        begin
            wval = lane_merge(ctrl_word, dat_i, sel_i);
            // flags are hardware owned; software only writes the control fields
            nxt_state.t2_ien = wval[interval_clock_pkg::B_T2_IEN];
            nxt_state.ext_en = wval[interval_clock_pkg::B_EXT_EN];
            nxt_state.maint  = wval[interval_clock_pkg::B_MAINT_HI:interval_clock_pkg::B_MAINT_LO];
            nxt_state.ov_ien = wval[interval_clock_pkg::B_OV_IEN];
            nxt_state.rate   = wval[interval_clock_pkg::B_RATE_HI:interval_clock_pkg::B_RATE_LO];
            nxt_state.mode   = interval_clock_pkg::mode_e'(
                wval[interval_clock_pkg::B_MODE_HI:interval_clock_pkg::B_MODE_LO]);
            nxt_state.go     = wval[interval_clock_pkg::B_GO];
        end

        // the counter register is read only; writes to it are acknowledged and dropped
        if (wr_now && adr_i == interval_clock_pkg::ADR_PRESET)
        begin
            wval = lane_merge(preset16, dat_i, sel_i);
            nxt_state.preset = wval[CNT_W-1:0];
        end

        // counting
        if (!state_ff.go)
        begin
            nxt_state.presc = '0;
        end
        else
        begin
            nxt_state.presc = state_ff.presc + 1'b1;
        end
        if (go_edge)
        begin
            nxt_state.presc = '0;
            nxt_state.count = state_ff.preset;
        end
        else if (tick)
        begin
            nxt_state.presc = '0;
            // reloading from preset keeps every interval the same length
            if (overflow)
            begin
                nxt_state.count = state_ff.preset;
            end
            else
            begin
                nxt_state.count = state_ff.count + 1'b1;
            end
        end


        // flags are set by hardware below; a set in the same cycle as a clear wins
        // start leading edge side effects
        if (go_edge)
        begin
            nxt_state.ov_flag = 1'b0;
            nxt_state.overrun = 1'b0;
            nxt_state.ext_en  = 1'b0;
            // start and external enable written together clear bit 15: enable must be set by an earlier write
            if (!state_ff.ext_en_prev)
            begin
                nxt_state.t2_flag = 1'b0;
            end
        end

        // overflow: single interval stops, repeated interval keeps going
        if (overflow)
        begin
            // overrun marks an overflow that software has not yet serviced
            if (state_ff.ov_flag)
            begin
                nxt_state.overrun = 1'b1;
            end
            nxt_state.ov_flag = 1'b1;
            if (state_ff.mode == interval_clock_pkg::MODE_SINGLE)
            begin
                nxt_state.go = 1'b0;
            end
            else
            begin
                nxt_state.go = nxt_state.go;
            end
        end

        // trigger events win over any clear in the same cycle
        if (trig_event)
        begin
            nxt_state.t2_flag = 1'b1;
            if (state_ff.ext_en)
            begin
                nxt_state.go = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_ff        <= '0;
            state_ff.mode   <= interval_clock_pkg::MODE_SINGLE;
            state_ff.count  <= interval_clock_pkg::CNT_RESET[CNT_W-1:0];
            state_ff.preset <= interval_clock_pkg::PRESET_RESET[CNT_W-1:0];
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign dat_o = state_ff.rdata;
    assign ack_o = state_ff.ack;
    assign t2_req      = state_ff.t2_flag && state_ff.t2_ien;
    assign ov_req      = state_ff.ov_flag && state_ff.ov_ien;
    assign irq_request = t2_req || ov_req;

endmodule

`default_nettype wire

// [test/interval_clock_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module interval_clock_checker
#(
    parameter int CNT_W = 16
)
(
    // watched design ports
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        external_trigger_two,
    input wire logic        irq_request
);
    logic ien2_ff;
    logic ienov_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // enables are written only by software, so a shadow of them is exact
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ien2_ff  <= 1'b0;
            ienov_ff <= 1'b0;
        end
        else if (ack_o && we_i && adr_i == interval_clock_pkg::ADR_CTRL)
        begin
            if (sel_i[1])
                ien2_ff <= dat_i[interval_clock_pkg::B_T2_IEN];
            if (sel_i[0])
                ienov_ff <= dat_i[interval_clock_pkg::B_OV_IEN];
        end
    end
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_dat_hold: assert property ($changed(dat_o) |-> ack_o && !we_i)
        else $error("read data changed outside a read");
    a_unmapped_zero: assert property (ack_o && !we_i && adr_i != 4'h0 && adr_i != 4'h4
        && adr_i != 4'h8 |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_trig_irq: assert property (ien2_ff && $rose(external_trigger_two)
        |-> ##[1:4] irq_request)
        else $error("trigger event raised no request");
    a_irq_enable: assert property (!ien2_ff && !ienov_ff |-> !irq_request)
        else $error("request with both enables off");
endmodule
bind interval_clock_control_status interval_clock_checker #(.CNT_W(CNT_W)) chk (
    .sys_clk(sys_clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .external_trigger_two(external_trigger_two), .irq_request(irq_request));
`default_nettype wire

// [test/test_interval_clock_control_status.sv]
`timescale 1ns/1ns
`default_nettype none
module test_interval_clock_control_status;
    logic        sys_clk = 1'b0;
    logic        nrst, cyc, stb, we, trig, ack_o, irq_request;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, dat_o, r;
    logic [31:0] exp_q[$];
    int          mismatches = 0;
    int          n_tests = 0;
    int          seed;
    always #20 sys_clk = ~sys_clk;
    interval_clock_control_status #(.CNT_W(4)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .external_trigger_two(trig), .irq_request(irq_request));
    task end_sim;
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        @(posedge sys_clk);
        while (ack_o !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            mismatches++;
            end_sim();
        end
        @(posedge sys_clk);
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back({16'h0000, e});
        bus(1'b0, a, 16'h0000);
    endtask
    task chk_irq(input logic e);
        @(negedge sys_clk);
        cmp({31'h0, irq_request}, {31'h0, e});
        @(posedge sys_clk);
    endtask
    task pulse;
        trig <= 1'b1;
        repeat (3) @(posedge sys_clk);
        trig <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task wait_irq(input int lim);
        int n;
        n = 0;
        while (irq_request !== 1'b1 && n < lim)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        if (n >= lim)
        begin
            mismatches++;
            end_sim();
        end
    endtask
    // read data is compared at the edge where ack is sampled high
    always @(posedge sys_clk)
        if (ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            cmp(dat_o, exp_q.pop_front());
    initial
    begin
        {cyc, stb, we, trig, nrst} = 5'h00;
        adr = 4'h0;
        sel = 4'h3;
        wdat = 32'h0000_0000;
        seed = 32'h0000_89f8;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(4'h0, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'hC, 16'h0000);
        repeat (4)
        begin
            r = $random(seed);
            bus(1'b1, 4'h0, r[15:0] & 16'hD0FE);
            rd(4'h0, r[15:0] & 16'h407E);
        end
        bus(1'b1, 4'h0, 16'h4000);
        pulse();
        rd(4'h0, 16'hC000);
        chk_irq(1'b1);
        bus(1'b1, 4'h0, 16'h4001);
        rd(4'h0, 16'h4001);
        chk_irq(1'b0);
        bus(1'b1, 4'h0, 16'h0000);
        bus(1'b1, 4'h0, 16'h2038);
        pulse();
        rd(4'h0, 16'h8039);
        bus(1'b1, 4'h0, 16'h0000);
        bus(1'b1, 4'h8, 16'h000E);
        bus(1'b1, 4'h0, 16'h0041);
        wait_irq(100);
        rd(4'h0, 16'h00C0);
        bus(1'b1, 4'h0, 16'h007B);
        rd(4'h0, 16'h007B);
        wait_irq(1000);
        rd(4'h0, 16'h00FB);
        repeat (600) @(posedge sys_clk);
        rd(4'h0, 16'h10FB);
        bus(1'b1, 4'h0, 16'h007A);
        bus(1'b1, 4'h0, 16'h007B);
        rd(4'h0, 16'h007B);
        end_sim();
    end
endmodule
`default_nettype wire
